// ==== rtl/khmc_top.sv ====
// Purpose: keyed hash controller, APB registers, pad sequencing and result delivery
// Assumes: external SHA-256 core, fuse store and system words on the same clock
// Notes: one word per cycle streamed, sixteen words per block
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "khmc_regs.svh"
module khmc_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [2:0] FUSE_KEY_SEL,
  input wire logic [255:0] FUSE_KEY,
  input wire logic [3:0] FUSE_PURPOSE,
  input wire logic DEBUG_SOFT_DISABLE_FUSE,
  input wire logic DEBUG_HARD_DISABLE_FUSE,
  input wire logic [255:0] DEBUG_UNLOCK_EXPECTED_WORDS,
  output logic JTAG_ENABLE,
  output logic SHA_INIT,
  output logic SHA_WVALID,
  output logic [31:0] SHA_WDATA,
  input wire logic SHA_DONE,
  input wire logic [255:0] SHA_DIGEST,
  output logic [255:0] SIG_KEY,
  output logic SIG_KEY_VALID
);
  khmc_pkg::khmc_regs_type r_r; // all state
  khmc_pkg::khmc_regs_type r_nxt; // next state
  logic [31:0] mem_rd; // registered message word
  logic acc; // apb access edge with pready high
  logic wr; // write takes effect this edge
  logic setup; // apb setup cycle
  logic msg_wr; // write into the message window

  // exact register hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // address inside a word window
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
    in_win = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
  endfunction

  // fuse purpose against configured purpose, combined key serves both downstream uses
  function automatic logic purpose_ok(input logic [3:0] cfg, input logic [3:0] fuse, input logic [2:0] sel);
    logic known;
    known = (cfg >= `KHMC_PUR_ALL) && (cfg <= `KHMC_PUR_UP);
    purpose_ok = known && (sel < `KHMC_KEY_BLOCKS) &&
      ((fuse == cfg) || ((fuse == `KHMC_PUR_ALL) && ((cfg == `KHMC_PUR_DBG) || (cfg == `KHMC_PUR_SIG))));
  endfunction

  // word idx of the block streamed in phase ph, word 0 is the high end
  function automatic logic [31:0] feed_word(input khmc_pkg::khmc_phase_type ph, input logic [3:0] idx,
                                            input logic [255:0] key, input logic [255:0] h,
                                            input logic [31:0] msg);
    logic [7:0] base;
    logic [31:0] kw;
    logic [31:0] hw;
    logic [31:0] tail;
    base = {3'(3'h7 - idx[2:0]), 5'h00};
    kw = key[base +: 32];
    hw = h[base +: 32];
    // second block of a 768-bit message: one bit, zeros, length
    tail = (idx == 4'h8) ? `KHMC_PAD_ONE : ((idx == `KHMC_LAST_WORD) ? `KHMC_LEN_768 : 32'h00000000);
    case (ph)
      khmc_pkg::PH_IPAD: feed_word = idx[3] ? `KHMC_IPAD : (kw ^ `KHMC_IPAD);
      khmc_pkg::PH_OPAD: feed_word = idx[3] ? `KHMC_OPAD : (kw ^ `KHMC_OPAD);
      khmc_pkg::PH_USER: feed_word = msg;
      khmc_pkg::PH_ZMSG: feed_word = idx[3] ? tail : 32'h00000000;
      default: feed_word = idx[3] ? tail : hw;
    endcase
  endfunction

  assign setup = PSEL && !PENABLE;
  assign acc = PSEL && PENABLE && r_r.pready;
  assign wr = acc && PWRITE;
  // message words are frozen while a block is hashed
  assign msg_wr = wr && !r_r.busy && in_win(PADDR, `KHMC_OFF_MSG_LO, `KHMC_OFF_MSG_HI);

  // message store, read in step with the fetch counter
  khmc_msg_mem #(.DEPTH(16), .WIDTH(32)) u_msg (
    .clk(CLK),
    .wr_en(msg_wr),
    .wr_idx(PADDR[5:2]),
    .wr_data(PWDATA),
    .rd_idx(r_r.cnt),
    .rd_data(mem_rd)
  );

  // next state of the whole block
  always_comb begin
    r_nxt = r_r;
    r_nxt.pready = 1'b0;
    r_nxt.pslverr = 1'b0;
    r_nxt.sha_init = 1'b0;
    r_nxt.sha_wvld = 1'b0;
    r_nxt.vld_d = 1'b0;
    r_nxt.init_d = 1'b0;
    // debug port open unless hard fuse set; soft fuse needs an unlock
    r_nxt.jtag_en = !DEBUG_HARD_DISABLE_FUSE && (!DEBUG_SOFT_DISABLE_FUSE || r_r.dbg_unl);

    // second stage of the stream, memory data is valid now
    if (r_r.vld_d) begin
      r_nxt.sha_wvld = 1'b1;
      r_nxt.sha_init = r_r.init_d;
      r_nxt.sha_wdata = feed_word(r_r.phase, r_r.cnt_d, FUSE_KEY, r_r.h1, mem_rd);
    end

    // apb setup: answer in the access cycle that follows
    if (setup) begin
      r_nxt.pready = 1'b1;
      r_nxt.prdata = 32'h00000000;
      if (hit(PADDR, `KHMC_OFF_MISMATCH) && !PWRITE) begin
        r_nxt.prdata = {31'h00000000, r_r.mismatch};
      end else if (hit(PADDR, `KHMC_OFF_BUSY) && !PWRITE) begin
        r_nxt.prdata = {31'h00000000, r_r.busy};
      end else if (in_win(PADDR, `KHMC_OFF_RES_LO, `KHMC_OFF_RES_HI) && !PWRITE) begin
        // only an upstream result is ever visible here
        if (r_r.res_vld) begin
          r_nxt.prdata = r_r.res[{3'(3'h7 - PADDR[4:2]), 5'h00} +: 32];
        end
      end else if (in_win(PADDR, `KHMC_OFF_MSG_LO, `KHMC_OFF_MSG_HI) && PWRITE) begin
        r_nxt.prdata = 32'h00000000;
      end else if ((hit(PADDR, `KHMC_OFF_START) || hit(PADDR, `KHMC_OFF_PURPOSE) || hit(PADDR, `KHMC_OFF_KEYSEL) ||
                    hit(PADDR, `KHMC_OFF_CFG_DONE) || hit(PADDR, `KHMC_OFF_BLOCK) ||
                    hit(PADDR, `KHMC_OFF_RES_DONE) || hit(PADDR, `KHMC_OFF_CLR_DBG) ||
                    hit(PADDR, `KHMC_OFF_CLR_SIG)) && PWRITE) begin
        // the two unused trigger slots between block and result done fall through to an error
        r_nxt.prdata = 32'h00000000;
      end else begin
        r_nxt.pslverr = 1'b1; // unmapped or wrong direction
      end
    end

    // discard derived results, independent of the sequencer
    if (wr && hit(PADDR, `KHMC_OFF_CLR_DBG) && PWDATA[`KHMC_BIT_TRIG]) begin
      r_nxt.dbg_unl = 1'b0;
    end
    if (wr && hit(PADDR, `KHMC_OFF_CLR_SIG) && PWDATA[`KHMC_BIT_TRIG]) begin
      r_nxt.sig_vld = 1'b0;
      r_nxt.sig_key = 256'h0;
    end

    // start works from any idle point and reopens configuration
    if (wr && hit(PADDR, `KHMC_OFF_START) && PWDATA[`KHMC_BIT_TRIG] && !r_r.busy) begin
      r_nxt.st = khmc_pkg::ST_CONF;
      r_nxt.mismatch = 1'b0;
      r_nxt.res_vld = 1'b0;
      r_nxt.res = 256'h0;
    end else begin
      case (r_r.st)
        khmc_pkg::ST_IDLE: begin
          r_nxt.st = khmc_pkg::ST_IDLE;
        end
        khmc_pkg::ST_CONF: begin
          // purpose and key writes only count while configuring
          if (wr && hit(PADDR, `KHMC_OFF_PURPOSE)) begin
            r_nxt.purpose = PWDATA[3:0];
          end
          if (wr && hit(PADDR, `KHMC_OFF_KEYSEL)) begin
            r_nxt.keysel = PWDATA[2:0];
          end
          if (wr && hit(PADDR, `KHMC_OFF_CFG_DONE) && PWDATA[`KHMC_BIT_TRIG]) begin
            if (purpose_ok(r_r.purpose, FUSE_PURPOSE, r_r.keysel)) begin
              r_nxt.mismatch = 1'b0;
              r_nxt.busy = 1'b1;
              r_nxt.phase = khmc_pkg::PH_IPAD;
              r_nxt.cnt = 4'h0;
              r_nxt.st = khmc_pkg::ST_FEED;
            end else begin
              r_nxt.mismatch = 1'b1;
              r_nxt.st = khmc_pkg::ST_IDLE;
            end
          end
        end
        khmc_pkg::ST_FEED: begin
          // fetch one word per cycle, memory answers next cycle
          r_nxt.vld_d = 1'b1;
          r_nxt.cnt_d = r_r.cnt;
          r_nxt.init_d = (r_r.cnt == 4'h0) &&
            ((r_r.phase == khmc_pkg::PH_IPAD) || (r_r.phase == khmc_pkg::PH_OPAD));
          r_nxt.cnt = 4'(r_r.cnt + 4'h1);
          if (r_r.cnt == `KHMC_LAST_WORD) begin
            r_nxt.st = khmc_pkg::ST_WAIT;
          end
        end
        khmc_pkg::ST_WAIT: begin
          // the core owns the digest; choose the next block when it is done
          if (SHA_DONE) begin
            r_nxt.cnt = 4'h0;
            r_nxt.st = khmc_pkg::ST_FEED;
            case (r_r.phase)
              khmc_pkg::PH_IPAD: begin
                if (r_r.purpose == `KHMC_PUR_UP) begin
                  r_nxt.busy = 1'b0;
                  r_nxt.st = khmc_pkg::ST_UPIDLE;
                end else begin
                  r_nxt.phase = khmc_pkg::PH_ZMSG;
                end
              end
              khmc_pkg::PH_USER: begin
                if (r_r.last) begin
                  r_nxt.h1 = SHA_DIGEST;
                  r_nxt.phase = khmc_pkg::PH_OPAD;
                end else begin
                  r_nxt.busy = 1'b0;
                  r_nxt.st = khmc_pkg::ST_UPIDLE;
                end
              end
              khmc_pkg::PH_ZMSG: begin
                r_nxt.h1 = SHA_DIGEST;
                r_nxt.phase = khmc_pkg::PH_OPAD;
              end
              khmc_pkg::PH_OPAD: begin
                r_nxt.phase = khmc_pkg::PH_OTAIL;
              end
              default: begin
                // final digest goes only to the consumers of its purpose, both downstream ones for the combined key
                r_nxt.busy = 1'b0;
                r_nxt.st = khmc_pkg::ST_DONE;
                if (r_r.purpose == `KHMC_PUR_UP) begin
                  r_nxt.res = SHA_DIGEST;
                  r_nxt.res_vld = 1'b1;
                end
                if ((r_r.purpose == `KHMC_PUR_DBG) || (r_r.purpose == `KHMC_PUR_ALL)) begin
                  r_nxt.dbg_unl = (SHA_DIGEST == DEBUG_UNLOCK_EXPECTED_WORDS);
                end
                if ((r_r.purpose == `KHMC_PUR_SIG) || (r_r.purpose == `KHMC_PUR_ALL)) begin
                  r_nxt.sig_key = SHA_DIGEST;
                  r_nxt.sig_vld = 1'b1;
                end
              end
            endcase
          end
        end
        khmc_pkg::ST_UPIDLE: begin
          // a block trigger hashes the sixteen stored words
          if (wr && hit(PADDR, `KHMC_OFF_BLOCK) && PWDATA[`KHMC_BIT_TRIG] && !r_r.busy) begin
            r_nxt.busy = 1'b1;
            r_nxt.last = PWDATA[`KHMC_BIT_LAST];
            r_nxt.phase = khmc_pkg::PH_USER;
            r_nxt.cnt = 4'h0;
            r_nxt.st = khmc_pkg::ST_FEED;
          end
        end
        khmc_pkg::ST_DONE: begin
          // closing drops the upstream result
          if (wr && hit(PADDR, `KHMC_OFF_RES_DONE) && PWDATA[`KHMC_BIT_TRIG]) begin
            r_nxt.res_vld = 1'b0;
            r_nxt.res = 256'h0;
            r_nxt.st = khmc_pkg::ST_IDLE;
          end
        end
        default: begin
          r_nxt.st = khmc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // one register for all state, cleared by the synchronous reset
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from state flops
  assign PRDATA = r_r.prdata;
  assign PREADY = r_r.pready;
  assign PSLVERR = r_r.pslverr;
  assign FUSE_KEY_SEL = r_r.keysel;
  assign JTAG_ENABLE = r_r.jtag_en;
  assign SHA_INIT = r_r.sha_init;
  assign SHA_WVALID = r_r.sha_wvld;
  assign SHA_WDATA = r_r.sha_wdata;
  assign SIG_KEY = r_r.sig_key;
  assign SIG_KEY_VALID = r_r.sig_vld;

  // checks beside the logic
  a_mismatch_idle: assert property (@(posedge CLK) disable iff (!RESETN)
    r_r.mismatch |-> !r_r.busy) else $error("busy while purposes disagree");
  a_cfg_busy: assert property (@(posedge CLK) disable iff (!RESETN)
    (r_r.st == khmc_pkg::ST_CONF && wr && hit(PADDR, `KHMC_OFF_CFG_DONE) && PWDATA[0] &&
     purpose_ok(r_r.purpose, FUSE_PURPOSE, r_r.keysel)) |=> r_r.busy && !r_r.mismatch)
    else $error("config done did not raise busy");
  a_res_hidden: assert property (@(posedge CLK) disable iff (!RESETN)
    r_r.res_vld |-> (r_r.purpose == `KHMC_PUR_UP)) else $error("downstream result readable");
  a_hard_off: assert property (@(posedge CLK) disable iff (!RESETN)
    DEBUG_HARD_DISABLE_FUSE |=> !JTAG_ENABLE) else $error("debug open despite hard fuse");
  a_unlock_keep: assert property (@(posedge CLK) disable iff (!RESETN)
    (r_r.dbg_unl && !(wr && hit(PADDR, `KHMC_OFF_CLR_DBG) && PWDATA[0]) && r_r.st != khmc_pkg::ST_WAIT)
    |=> r_r.dbg_unl) else $error("unlock lost without clear");
  a_sig_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr && hit(PADDR, `KHMC_OFF_CLR_SIG) && PWDATA[0]) |=> !SIG_KEY_VALID ##1 (SIG_KEY == 256'h0))
    else $error("signature key not discarded");
  a_block_len: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(SHA_WVALID) |-> ##15 SHA_WVALID ##1 !SHA_WVALID) else $error("block not sixteen words");
  a_ipad_word: assert property (@(posedge CLK) disable iff (!RESETN)
    (SHA_INIT && r_r.phase == khmc_pkg::PH_IPAD) |-> (SHA_WDATA == ($past(FUSE_KEY[255:224]) ^ `KHMC_IPAD)))
    else $error("inner pad word wrong");
  a_done_idle: assert property (@(posedge CLK) disable iff (!RESETN)
    (r_r.st == khmc_pkg::ST_DONE) |-> !r_r.busy) else $error("busy after finish");
  a_busy_block: assert property (@(posedge CLK) disable iff (!RESETN)
    (r_r.busy && wr && hit(PADDR, `KHMC_OFF_BLOCK)) |=> $stable(r_r.last))
    else $error("block accepted while busy");
  a_start_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr && hit(PADDR, `KHMC_OFF_START) && PWDATA[0] && !r_r.busy) |=> (!r_r.mismatch && !r_r.res_vld))
    else $error("start left stale status");
endmodule

// ==== rtl/khmc_regs.svh ====
// Purpose: register offsets, purpose codes and pad constants of the keyed hash block
// Assumes: byte addresses on a 12-bit APB address, one aligned 32-bit word per register
// Notes: definitions only
`ifndef KHMC_REGS_SVH
`define KHMC_REGS_SVH

// trigger, configuration and status registers
`define KHMC_OFF_START 12'h040
`define KHMC_OFF_PURPOSE 12'h044
`define KHMC_OFF_KEYSEL 12'h048
`define KHMC_OFF_CFG_DONE 12'h04C
`define KHMC_OFF_BLOCK 12'h050
`define KHMC_OFF_RES_DONE 12'h05C
`define KHMC_OFF_CLR_DBG 12'h060
`define KHMC_OFF_CLR_SIG 12'h064
`define KHMC_OFF_MISMATCH 12'h068
`define KHMC_OFF_BUSY 12'h06C
// message and result windows
`define KHMC_OFF_MSG_LO 12'h080
`define KHMC_OFF_MSG_HI 12'h0BC
`define KHMC_OFF_RES_LO 12'h0C0
`define KHMC_OFF_RES_HI 12'h0DC

// field positions
`define KHMC_BIT_TRIG 0
`define KHMC_BIT_LAST 1

// key purpose codes
`define KHMC_PUR_ALL 4'h5
`define KHMC_PUR_DBG 4'h6
`define KHMC_PUR_SIG 4'h7
`define KHMC_PUR_UP 4'h8

// fuse key blocks 0 to 5
`define KHMC_KEY_BLOCKS 3'h6

// pad words and the tail of a 768-bit second block
`define KHMC_IPAD 32'h36363636
`define KHMC_OPAD 32'h5C5C5C5C
`define KHMC_PAD_ONE 32'h80000000
`define KHMC_LEN_768 32'h00000300
`define KHMC_LAST_WORD 4'hF
`endif

// ==== rtl/khmc_pkg.sv ====
// Purpose: types of the keyed hash block
// Assumes: nothing
// Notes: constants live in khmc_regs.svh
package khmc_pkg;
  // gray sequence along idle, conf, feed, wait, up-idle, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CONF = 3'h1, ST_FEED = 3'h3, ST_WAIT = 3'h2, ST_UPIDLE = 3'h6, ST_DONE = 3'h7
  } khmc_state_type;

  // which 512-bit block is streamed to the hash core
  typedef enum logic [2:0] {
    PH_IPAD = 3'h0, PH_USER = 3'h1, PH_ZMSG = 3'h2, PH_OPAD = 3'h3, PH_OTAIL = 3'h4
  } khmc_phase_type;

  typedef struct packed {
    khmc_state_type st;
    khmc_phase_type phase;
    logic [3:0] cnt; // word being fetched
    logic vld_d; // fetch stage valid
    logic init_d; // fetch stage opens a hash
    logic [3:0] cnt_d; // fetch stage word index
    logic [3:0] purpose;
    logic [2:0] keysel;
    logic mismatch;
    logic busy;
    logic last;
    logic [255:0] h1; // inner digest
    logic [255:0] res; // upstream result
    logic res_vld;
    logic dbg_unl;
    logic [255:0] sig_key;
    logic sig_vld;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sha_init;
    logic sha_wvld;
    logic [31:0] sha_wdata;
    logic jtag_en;
  } khmc_regs_type;
endpackage

// ==== rtl/khmc_msg_mem.sv ====
// Purpose: sixteen-word message store for upstream blocks
// Assumes: one write and one read port on one clock
// Notes: read data is registered, one cycle behind the index
`timescale 1ns/10ps
module khmc_msg_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH]; // no reset, software fills before use

  // write port and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
    rd_data <= mem_r[rd_idx];
  end
endmodule

// ==== verif/khmc_partner.sv ====
// Purpose: far side of the keyed hash block: fuse key store and a behavioural hash core
// Assumes: fuse contents come from the bench and stay static during a run
// Notes: digest is a running word sum, not a real hash, yet every streamed word shows in it
`timescale 1ns/10ps
module khmc_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [255:0] keys [6],
  input wire logic [3:0] purps [8],
  input wire logic [3:0] lat,
  input wire logic [2:0] key_sel,
  output logic [255:0] fuse_key,
  output logic [3:0] fuse_purpose,
  input wire logic sha_init,
  input wire logic sha_wvalid,
  input wire logic [31:0] sha_wdata,
  output logic sha_done,
  output logic [255:0] sha_digest
);
  logic [31:0] sum; // sum since the last hash opening
  logic [3:0] n; // word count inside a block
  int cd; // cycles left until done
  // key of the selected block; an index past the last block reads all ones
  assign fuse_key = key_sel < 3'h6 ? keys[key_sel] : '1;
  assign fuse_purpose = purps[key_sel];
  // hash core: a word every cycle, done after a chosen latency
  always @(posedge clk) begin
    sha_done <= 1'b0;
    sha_digest <= ~sha_digest; // not meaningful outside the done pulse
    if (!resetn) begin
      n <= 4'h0;
      cd <= 0;
      sum <= 32'h0;
      sha_digest <= 256'h0;
    end else begin
      if (cd == 1) begin
        sha_done <= 1'b1;
        for (int j = 0; j < 8; j++) sha_digest[255 - 32 * j -: 32] <= sum + 32'(j);
      end
      if (cd > 0) cd <= cd - 1;
      if (sha_wvalid) begin
        sum <= (sha_init ? 32'h0 : sum) + sha_wdata;
        n <= n + 4'h1;
        if (n == 4'hF) cd <= int'(lat) + 1;
      end
    end
  end
endmodule

// ==== verif/khmc_tb_top.sv ====
// Purpose: self-checking bench of the keyed hash controller
// Assumes: khmc_partner stands in for the fuses and the hash core
// Notes: sum-based digest keeps expected values cheap while tracing every word
`timescale 1ns/10ps
`include "khmc_regs.svh"
module khmc_tb_top;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, JTAG_ENABLE, SHA_INIT, SHA_WVALID, SHA_DONE;
  logic DEBUG_SOFT_DISABLE_FUSE, DEBUG_HARD_DISABLE_FUSE, SIG_KEY_VALID, noted;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, SHA_WDATA, acc;
  logic [2:0] FUSE_KEY_SEL;
  logic [3:0] FUSE_PURPOSE, lat;
  logic [255:0] FUSE_KEY, DEBUG_UNLOCK_EXPECTED_WORDS, SHA_DIGEST, SIG_KEY, fin;
  logic [255:0] keys [6];
  logic [3:0] purps [8];
  logic [32:0] exp_sha [$]; // init flag and word still to be streamed
  logic [33:0] exp_ap [$]; // data checked, error, data
  logic [33:0] e_ap;
  logic [3:0] mm_p [6] = '{4'h6, 4'h7, 4'h8, 4'h5, 4'h6, 4'h9};
  logic [2:0] mm_k [6] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h6, 3'h3};
  logic [3:0] mm_f [6] = '{4'h7, 4'h6, 4'h5, 4'h6, 4'h6, 4'h9};
  int n_fail = 0;
  int checks_done = 0;
  khmc_top dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FUSE_KEY_SEL(FUSE_KEY_SEL),
    .FUSE_KEY(FUSE_KEY), .FUSE_PURPOSE(FUSE_PURPOSE), .DEBUG_SOFT_DISABLE_FUSE(DEBUG_SOFT_DISABLE_FUSE),
    .DEBUG_HARD_DISABLE_FUSE(DEBUG_HARD_DISABLE_FUSE), .DEBUG_UNLOCK_EXPECTED_WORDS(DEBUG_UNLOCK_EXPECTED_WORDS),
    .JTAG_ENABLE(JTAG_ENABLE), .SHA_INIT(SHA_INIT), .SHA_WVALID(SHA_WVALID), .SHA_WDATA(SHA_WDATA),
    .SHA_DONE(SHA_DONE), .SHA_DIGEST(SHA_DIGEST), .SIG_KEY(SIG_KEY), .SIG_KEY_VALID(SIG_KEY_VALID));
  khmc_partner partner (.clk(CLK), .resetn(RESETN), .keys(keys), .purps(purps), .lat(lat),
    .key_sel(FUSE_KEY_SEL), .fuse_key(FUSE_KEY), .fuse_purpose(FUSE_PURPOSE), .sha_init(SHA_INIT),
    .sha_wvalid(SHA_WVALID), .sha_wdata(SHA_WDATA), .sha_done(SHA_DONE), .sha_digest(SHA_DIGEST));
  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (60000) @(posedge CLK);
    n_fail++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [255:0] g, input logic [255:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // scoreboard: oldest note taken whenever a result shows
  always @(posedge CLK) begin
    if (SHA_WVALID) cmp(256'({SHA_INIT, SHA_WDATA}), 256'(exp_sha.size() ? exp_sha.pop_front() : ~{SHA_INIT, SHA_WDATA}));
    if (noted && PSEL && PENABLE && PREADY) begin
      e_ap = exp_ap.pop_front();
      cmp(256'({PSLVERR, e_ap[33] ? PRDATA : 32'h0}), 256'(e_ap[32:0]));
    end
  end
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic nt,
                     output logic [31:0] q);
    int t;
    t = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    noted <= nt;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      t++;
    end while (PREADY !== 1'b1 && t < 50);
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    noted <= 1'b0;
    if (t >= 50) n_fail++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, 1'b0, q);
  endtask
  // noted transfer, judged by the scoreboard
  task automatic chk(input logic w, input logic [11:0] a, input logic [33:0] x);
    logic [31:0] q;
    exp_ap.push_back(x);
    apb(w, a, 32'h1, 1'b1, q);
  endtask
  // poll busy until it reads 0, bounded
  task automatic wait_idle();
    logic [31:0] q;
    int i;
    i = 0;
    do begin
      apb(1'b0, `KHMC_OFF_BUSY, 32'h0, 1'b0, q);
      i++;
    end while (q[0] !== 1'b0 && i < 200);
    if (i >= 200) n_fail++;
  endtask
  task automatic settle();
    repeat (2) @(posedge CLK);
  endtask
  task automatic cfg(input logic [31:0] p, input logic [31:0] k);
    wr(`KHMC_OFF_START, 32'h1);
    wr(`KHMC_OFF_PURPOSE, p);
    wr(`KHMC_OFF_KEYSEL, k);
    wr(`KHMC_OFF_CFG_DONE, 32'h1);
  endtask
  // expected stream model
  task automatic put(input logic i, input logic [31:0] w);
    exp_sha.push_back({i, w});
    acc = acc + w;
  endtask
  task automatic key_blk(input logic [255:0] k, input logic [31:0] pad);
    acc = 32'h0;
    for (int j = 0; j < 16; j++) put(j == 0, j < 8 ? k[255 - 32 * j -: 32] ^ pad : pad);
  endtask
  function automatic logic [255:0] dig(input logic [31:0] s);
    for (int j = 0; j < 8; j++) dig[255 - 32 * j -: 32] = s + 32'(j);
  endfunction
  task automatic tail_blk(input logic [255:0] h);
    for (int j = 0; j < 16; j++) put(1'b0, j < 8 ? h[255 - 32 * j -: 32] : j == 8 ? `KHMC_PAD_ONE :
                                     j == 15 ? `KHMC_LEN_768 : 32'h0);
  endtask
  // outer pass over the inner digest, final digest left in fin
  task automatic outer(input logic [255:0] k);
    logic [255:0] h1;
    h1 = dig(acc);
    key_blk(k, `KHMC_OPAD);
    tail_blk(h1);
    fin = dig(acc);
  endtask
  // downstream run: debug unlock and signature key delivery
  task automatic run_down(input logic [3:0] p, input logic [2:0] k, input logic [3:0] f, input logic ok,
                        input logic hard);
    lat <= 4'($urandom % 6);
    purps[k] <= f;
    key_blk(keys[k], `KHMC_IPAD);
    tail_blk(256'h0);
    outer(keys[k]);
    DEBUG_UNLOCK_EXPECTED_WORDS <= ok ? fin : ~fin;
    DEBUG_HARD_DISABLE_FUSE <= hard;
    cfg({28'h0, p}, {29'h0, k});
    chk(1'b0, `KHMC_OFF_BUSY, {2'b10, 32'h1});
    wait_idle();
    chk(1'b0, `KHMC_OFF_MISMATCH, {2'b10, 32'h0});
    cmp(256'(JTAG_ENABLE), 256'(p != 7 && ok && !hard));
    cmp(256'(SIG_KEY_VALID), 256'(p != 6));
    if (p != 6) cmp(SIG_KEY, fin);
    chk(1'b0, `KHMC_OFF_RES_LO, {2'b10, 32'h0});
    wr(`KHMC_OFF_CLR_DBG, 32'h1);
    wr(`KHMC_OFF_CLR_SIG, 32'h1);
    settle();
    cmp(256'({JTAG_ENABLE, SIG_KEY_VALID}), 256'h0);
    $display("test downstream purpose %0h done", p);
  endtask
  // upstream run: two user blocks, the second marked last
  task automatic run_up();
    logic [31:0] m;
    purps[5] <= 4'h8;
    key_blk(keys[5], `KHMC_IPAD);
    cfg(32'h8, 32'h5);
    wait_idle();
    for (int b = 0; b < 2; b++) begin
      for (int j = 0; j < 16; j++) begin
        m = $urandom;
        put(1'b0, m);
        wr(`KHMC_OFF_MSG_LO + 12'(4 * j), m);
      end
      if (b == 1) outer(keys[5]);
      wr(`KHMC_OFF_BLOCK, b == 1 ? 32'h3 : 32'h1);
      wr(`KHMC_OFF_BLOCK, 32'h3);
      wait_idle();
    end
    for (int j = 0; j < 8; j++) chk(1'b0, `KHMC_OFF_RES_LO + 12'(4 * j), {2'b10, fin[255 - 32 * j -: 32]});
    cmp(256'(SIG_KEY_VALID), 256'h0);
    chk(1'b1, `KHMC_OFF_RES_LO, {2'b01, 32'h0});
    wr(`KHMC_OFF_RES_DONE, 32'h1);
    chk(1'b0, `KHMC_OFF_BUSY, {2'b10, 32'h0});
    $display("test upstream done");
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hF383));
    RESETN = 1'b0;
    {PSEL, PENABLE, PWRITE, noted, DEBUG_SOFT_DISABLE_FUSE, DEBUG_HARD_DISABLE_FUSE} = 6'h0;
    {PADDR, PWDATA} = 44'h0;
    DEBUG_UNLOCK_EXPECTED_WORDS = 256'h0;
    lat = 4'h0;
    purps = '{default: 4'h0};
    for (int k = 0; k < 6; k++) for (int w = 0; w < 8; w++) keys[k][255 - 32 * w -: 32] = $urandom;
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    settle();
    cmp(256'(JTAG_ENABLE), 256'h1);
    DEBUG_SOFT_DISABLE_FUSE <= 1'b1;
    settle();
    cmp(256'(JTAG_ENABLE), 256'h0);
    chk(1'b0, `KHMC_OFF_START, {2'b01, 32'h0});
    chk(1'b1, `KHMC_OFF_BUSY, {2'b01, 32'h0});
    chk(1'b0, 12'h0F0, {2'b01, 32'h0});
    chk(1'b1, 12'h054, {2'b01, 32'h0});
    chk(1'b0, `KHMC_OFF_RES_LO, {2'b10, 32'h0});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      purps[mm_k[i]] <= mm_f[i];
      cfg({28'h0, mm_p[i]}, {29'h0, mm_k[i]});
      chk(1'b0, `KHMC_OFF_MISMATCH, {2'b10, 32'h1});
      chk(1'b0, `KHMC_OFF_BUSY, {2'b10, 32'h0});
    end
    $display("test mismatch done");
    run_down(4'h6, 3'h2, 4'h5, 1'b1, 1'b0);
    run_down(4'h6, 3'h1, 4'h6, 1'b0, 1'b0);
    run_down(4'h5, 3'h0, 4'h5, 1'b1, 1'b1);
    run_down(4'h7, 3'h4, 4'h7, 1'b1, 1'b0);
    run_up();
    cmp(256'(exp_sha.size()), 256'h0);
    conclude();
  end
endmodule
